// file: tsoc_dev.sv
`timescale 1ns/1ps
// ============================================================
// Operation
// R1: flag bits 7..5 only clear on written zero.
// R2: reset/standby: channel 0 is 00, channel 1 is 10.
// R3: match B sets flag bit 7.
// R4: match B flag clears after read-one then write-zero.
// R5: match A sets flag bit 6.
// R6: match A flag clears after read-one then write-zero.
// R7: transfer with disable-select zero clears match flag.
// R8: counter wrap FF to 00 sets bit 5.
// R9: wrap flag clears after read-one then write-zero.
// R10: channel 0 bit 4 enables conversion start requests.
// R11: channel 1 bit 4 reads one, ignores writes.
// R12: bits 3..2 select match B output action.
// R13: bits 1..0 select match A output action.
// R14: simultaneous matches: toggle beats one beats zero.
// R15: all four select bits zero disables output.
// R16: output is zero after reset until match.
// R17: stop bit set stops timer after bus cycle.
// R18: no register access while module stopped.
// R19: stop register resets to 3FFF, keeps in standby; here hardware standby also resets it to 3FFF.
// R20: clearing stop bit runs timer; reset keeps stopped.
// R21: each flag interrupts only when its enable set.
// R22: channel 0 match A with enable starts conversion.
// R23: match sampled in last state before counter update.
// R24: writing one or unarmed zero leaves flag unchanged.
module tsoc_dev
	import tsoc_pkg::*;
(
	// Clock and reset.
	input  wire logic                  sys_clk,
	input  wire logic                  arst_n,
	// Register link from the controller.
	tsoc_if.dev                        bus,
	// Hardware standby request, asynchronous pin.
	input  wire logic                  hw_standby,
	// Counter side, per channel.
	input  wire logic [NCH-1:0][7:0]   cnt_val,
	input  wire logic [NCH-1:0][7:0]   constant_a,
	input  wire logic [NCH-1:0][7:0]   constant_b,
	input  wire logic [NCH-1:0]        cnt_upd,
	// Interrupt enables from the channel control registers.
	input  wire logic [NCH-1:0]        ie_match_a,
	input  wire logic [NCH-1:0]        ie_match_b,
	input  wire logic [NCH-1:0]        ie_wrap,
	// Transfer controller activations.
	input  wire logic [NCH-1:0]        xfer_done_a,
	input  wire logic [NCH-1:0]        xfer_done_b,
	input  wire logic [NCH-1:0]        disable_after_transfer_select,
	// Interrupt requests.
	output logic      [NCH-1:0]        match_a_irq,
	output logic      [NCH-1:0]        match_b_irq,
	output logic      [NCH-1:0]        wrap_irq,
	// Conversion start and timer outputs.
	output logic                       conv_start,
	output logic      [NCH-1:0]        tmo,
	output logic      [NCH-1:0]        tmo_oe,
	output logic                       timer_run
);

	// ============================================================
	// State.
	localparam tsoc_dev_s RST = '{
		flag:      '0,
		armed:     '0,
		conversion_trigger_enable:      RST_CH0[CONVERSION_TRIGGER_ENABLE_BIT],
		os:        '0,
		tmo:       '0,
		stop:      RST_STOP,
		ack:       1'b0,
		rdata:     '0,
		ad_start:  1'b0,
		stby_sync: '0
	};

	tsoc_dev_s               s_ff;
	tsoc_dev_s               nxt_s;
	logic      [NCH-1:0][2:0] ev;
	logic      [NCH-1:0][1:0] act;
	logic                    stopped;

	assign stopped = s_ff.stop[STOP_BIT];

	// ============================================================
	// Per channel match detection and output action choice.
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		logic [1:0] act_a;
		logic [1:0] act_b;
		// Matches are taken only on the update strobe, so a match that
		// holds for many cycles still sets the flag once per count.
		assign ev[c][F_MB]   = cnt_upd[c] && !stopped &&
		                       (cnt_val[c] == constant_b[c]);  // R3 R23
		assign ev[c][F_MA]   = cnt_upd[c] && !stopped &&
		                       (cnt_val[c] == constant_a[c]);  // R5 R23
		assign ev[c][F_WRAP] = cnt_upd[c] && !stopped &&
		                       (cnt_val[c] == CNT_MAX);        // R8
		assign act_b = ev[c][F_MB] ? s_ff.os[c][OS_MSB:OS_B_LSB]
		                           : ACT_NONE;                  // R12
		assign act_a = ev[c][F_MA] ? s_ff.os[c][OS_A_MSB:0]
		                           : ACT_NONE;                  // R13
		// The action codes are ordered by priority, so the larger wins.
		assign act[c] = (act_a > act_b) ? act_a : act_b;        // R14
		assign match_a_irq[c] = s_ff.flag[c][F_MA] && ie_match_a[c]; // R21
		assign match_b_irq[c] = s_ff.flag[c][F_MB] && ie_match_b[c]; // R21
		assign wrap_irq[c]    = s_ff.flag[c][F_WRAP] && ie_wrap[c];  // R21
		assign tmo_oe[c]      = |s_ff.os[c];                         // R15
	end

	// ============================================================
	// Register view of one flags/output register.
	function automatic logic [7:0] view(input tsoc_dev_s s, input int c);
		logic [7:0] v;
		v = {s.flag[c], RST_CH1[CONVERSION_TRIGGER_ENABLE_BIT], s.os[c]};
		if (c == 0) begin
			v[CONVERSION_TRIGGER_ENABLE_BIT] = s.conversion_trigger_enable;
		end
		return v;                                               // R11
	endfunction : view

	// ============================================================
	// Next state: bus access, transfer clears, then hardware sets, so
	// an event in the cycle of a clear still leaves its flag set.
	always_comb begin
		int         ch;
		logic [7:0] wb;
		ch = 0;
		wb = bus.wdata[7:0];
		nxt_s = s_ff;
		nxt_s.ack = 1'b0;
		nxt_s.ad_start = 1'b0;

		// Bus access: one cycle per request, answered the next edge.
		if (bus.req && !s_ff.ack) begin
			nxt_s.ack = 1'b1;
			nxt_s.rdata = '0;
			ch = (bus.addr == IDX_CH1) ? 1 : 0;
			if (bus.addr == IDX_STOP) begin
				if (bus.we) begin
					nxt_s.stop = bus.wdata;                    // R17 R20
				end else begin
					nxt_s.rdata = s_ff.stop;
				end
			end else if ((bus.addr == IDX_CH0 || bus.addr == IDX_CH1)
			             && !stopped) begin                    // R18
				if (bus.we) begin
					// Only an armed flag with a written zero clears;
					// the arming is used up by any write.
					nxt_s.flag[ch] = s_ff.flag[ch] &
					    ~(s_ff.armed[ch] & ~wb[FLG_MSB:FLG_LSB]); // R1 R4 R6 R9 R24
					nxt_s.armed[ch] = '0;
					nxt_s.os[ch] = wb[OS_MSB:0];                // R12 R13
					if (ch == 0) begin
						nxt_s.conversion_trigger_enable = wb[CONVERSION_TRIGGER_ENABLE_BIT];              // R10
					end
				end else begin
					nxt_s.rdata = {8'h00, view(s_ff, ch)};
					nxt_s.armed[ch] = s_ff.armed[ch] | s_ff.flag[ch];
				end
			end
		end

		// Per channel transfer clears, sets and output update.
		for (int c = 0; c < NCH; c++) begin
			if (xfer_done_a[c] && !disable_after_transfer_select[c]) begin
				nxt_s.flag[c][F_MA] = 1'b0;                     // R7
			end
			if (xfer_done_b[c] && !disable_after_transfer_select[c]) begin
				nxt_s.flag[c][F_MB] = 1'b0;                     // R7
			end
			nxt_s.flag[c] = nxt_s.flag[c] | ev[c];
			case (act[c])
				ACT_ZERO: nxt_s.tmo[c] = 1'b0;
				ACT_ONE:  nxt_s.tmo[c] = 1'b1;
				ACT_TGL:  nxt_s.tmo[c] = ~s_ff.tmo[c];
				default:  nxt_s.tmo[c] = s_ff.tmo[c];           // R16
			endcase
		end
		nxt_s.ad_start = ev[0][F_MA] && s_ff.conversion_trigger_enable;              // R22

		// Hardware standby puts every register back to reset.
		if (s_ff.stby_sync[1]) begin
			nxt_s = RST;                                        // R2 R19
		end
		nxt_s.stby_sync = {s_ff.stby_sync[0], hw_standby};
	end

	// ============================================================
	// State register.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_ff <= RST;                                        // R2 R19
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ============================================================
	// Outputs.
	assign bus.ack    = s_ff.ack;
	assign bus.rdata  = s_ff.rdata;
	assign conv_start = s_ff.ad_start;
	assign tmo        = s_ff.tmo;
	assign timer_run  = !stopped;                               // R20

endmodule : tsoc_dev

// file: tsoc_pkg.sv
// ============================================================
// Shared constants and types for the timer status and output link.
package tsoc_pkg;

	// ============================================================
	// Geometry.
	localparam int          NCH        = 2;
	localparam int          DW         = 16;
	localparam int          AW         = 2;

	// ============================================================
	// Register indices on the device link.
	localparam logic [1:0]  IDX_CH0    = 2'h0;
	localparam logic [1:0]  IDX_CH1    = 2'h1;
	localparam logic [1:0]  IDX_STOP   = 2'h2;

	// ============================================================
	// Field positions inside a flags/output register.
	localparam int          FLG_LSB    = 5;
	localparam int          FLG_MSB    = 7;
	localparam int          CONVERSION_TRIGGER_ENABLE_BIT   = 4;
	localparam int          OS_MSB     = 3;
	localparam int          OS_B_LSB   = 2;
	localparam int          OS_A_MSB   = 1;
	// Flag index within the three-bit flag group.
	localparam int          F_WRAP     = 0;
	localparam int          F_MA       = 1;
	localparam int          F_MB       = 2;
	// Module stop register: timer stop bit position.
	localparam int          STOP_BIT   = 12;

	// ============================================================
	// Reset values and counter maximum.
	localparam logic [7:0]  RST_CH0    = 8'h00;
	localparam logic [7:0]  RST_CH1    = 8'h10;
	localparam logic [15:0] RST_STOP   = 16'h3FFF;
	localparam logic [7:0]  CNT_MAX    = 8'hFF;

	// ============================================================
	// Compare output actions; the code value doubles as priority.
	localparam logic [1:0]  ACT_NONE   = 2'h0;
	localparam logic [1:0]  ACT_ZERO   = 2'h1;
	localparam logic [1:0]  ACT_ONE    = 2'h2;
	localparam logic [1:0]  ACT_TGL    = 2'h3;

	// ============================================================
	// Controller register map on Wishbone (byte addresses).
	localparam logic [3:0]  WB_CMD     = 4'h0;
	localparam logic [3:0]  WB_STAT    = 4'h4;
	localparam int          CMD_DAT_LSB = 0;
	localparam int          CMD_ADR_LSB = 16;
	localparam int          CMD_WE_BIT = 18;
	localparam int          CMD_GO_BIT = 31;
	localparam int          STAT_BUSY  = 16;

	// ============================================================
	// Device state.
	typedef struct packed {
		logic [NCH-1:0][2:0] flag;
		logic [NCH-1:0][2:0] armed;
		logic                conversion_trigger_enable;
		logic [NCH-1:0][3:0] os;
		logic [NCH-1:0]      tmo;
		logic [DW-1:0]       stop;
		logic                ack;
		logic [DW-1:0]       rdata;
		logic                ad_start;
		logic [1:0]          stby_sync;
	} tsoc_dev_s;

	// Controller link states, one-hot.
	typedef enum logic [1:0] {
		HS_IDLE = 2'b01,
		HS_WAIT = 2'b10
	} tsoc_hst_e;

	typedef struct packed {
		tsoc_hst_e           st;
		logic [AW-1:0]       addr;
		logic                we;
		logic [DW-1:0]       wdata;
		logic [DW-1:0]       rdata;
		logic                wb_ack;
		logic [31:0]         wb_dat;
	} tsoc_hst_s;

endpackage : tsoc_pkg

// file: tsoc_if.sv
`timescale 1ns/1ps
// ============================================================
// Register link between the controller and the timer device.
interface tsoc_if;
	import tsoc_pkg::*;
	logic                req;
	logic                we;
	logic [AW-1:0]       addr;
	logic [DW-1:0]       wdata;
	logic [DW-1:0]       rdata;
	logic                ack;

	modport dev  (input req, we, addr, wdata, output rdata, ack);
	modport host (output req, we, addr, wdata, input rdata, ack);
endinterface : tsoc_if

// file: tsoc_host.sv
`timescale 1ns/1ps
// ============================================================
// Controller end: takes one register access order over Wishbone,
// runs it on the device link and keeps the read data.
module tsoc_host
	import tsoc_pkg::*;
(
	// Clock and reset.
	input  wire logic          sys_clk,
	input  wire logic          arst_n,
	// Wishbone classic slave.
	input  wire logic          wb_cyc_i,
	input  wire logic          wb_stb_i,
	input  wire logic          wb_we_i,
	input  wire logic [3:0]    wb_adr_i,
	input  wire logic [3:0]    wb_sel_i,
	input  wire logic [31:0]   wb_dat_i,
	output logic      [31:0]   wb_dat_o,
	output logic               wb_ack_o,
	// Link to the device.
	tsoc_if.host               link
);

	// ============================================================
	// State.
	localparam tsoc_hst_s RST = '{
		st:     HS_IDLE,
		addr:   '0,
		we:     1'b0,
		wdata:  '0,
		rdata:  '0,
		wb_ack: 1'b0,
		wb_dat: '0
	};

	tsoc_hst_s s_ff;
	tsoc_hst_s nxt_s;

	// ============================================================
	// Next state. An order written while busy is dropped, because
	// the link carries one access at a time; software polls busy.
	always_comb begin
		logic take;
		take = wb_cyc_i && wb_stb_i && !s_ff.wb_ack;
		nxt_s = s_ff;
		nxt_s.wb_ack = take;
		if (take) begin
			nxt_s.wb_dat = '0;
			if (wb_adr_i == WB_STAT && !wb_we_i) begin
				nxt_s.wb_dat[DW-1:0]  = s_ff.rdata;
				nxt_s.wb_dat[STAT_BUSY] = (s_ff.st == HS_WAIT);
			end
		end
		case (s_ff.st)
			HS_IDLE: begin
				if (take && wb_we_i && wb_adr_i == WB_CMD && wb_sel_i[3]
				    && wb_dat_i[CMD_GO_BIT]) begin
					nxt_s.st = HS_WAIT;
					nxt_s.addr = wb_dat_i[CMD_ADR_LSB +: AW];
					nxt_s.we = wb_dat_i[CMD_WE_BIT];
					nxt_s.wdata = wb_dat_i[CMD_DAT_LSB +: DW];
				end
			end
			HS_WAIT: begin
				if (link.ack) begin
					nxt_s.st = HS_IDLE;
					if (!s_ff.we) begin
						nxt_s.rdata = link.rdata;
					end
				end
			end
			default: nxt_s.st = HS_IDLE;
		endcase
	end

	// ============================================================
	// State register.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_ff <= RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ============================================================
	// Outputs.
	assign wb_ack_o   = s_ff.wb_ack;
	assign wb_dat_o   = s_ff.wb_dat;
	assign link.req   = (s_ff.st == HS_WAIT);
	assign link.we    = s_ff.we;
	assign link.addr  = s_ff.addr;
	assign link.wdata = s_ff.wdata;

endmodule : tsoc_host

// file: tsoc_asserts.sv
`timescale 1ns/1ps
// =======
// Link protocol and register view checks.
module tsoc_asserts
	import tsoc_pkg::*;
(
	// Clock and reset.
	input wire logic          sys_clk,
	input wire logic          arst_n,
	// Hardware standby pin, as driven into the device.
	input wire logic          hw_standby,
	// Device link.
	input wire logic          req,
	input wire logic          we,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	input wire logic [DW-1:0] rdata,
	input wire logic          ack
);
	logic          t_we_ff;
	logic          t_bit_ff;
	logic [AW-1:0] t_addr_ff;
	logic          stop_ff;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	// Keep the taken order, since the answer cycle may carry a new one.
	// Hardware standby puts the stop mirror back to its stopped reset
	// state; the bench keeps the link idle while standby settles.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			t_we_ff   <= 1'b0;
			t_bit_ff  <= 1'b0;
			t_addr_ff <= '0;
			stop_ff   <= 1'b1;
		end else begin
			if (req && !ack) begin
				t_we_ff   <= we;
				t_bit_ff  <= wdata[STOP_BIT];
				t_addr_ff <= addr;
			end
			if (hw_standby)
				stop_ff <= RST_STOP[STOP_BIT];
			else if (ack && t_we_ff && t_addr_ff == IDX_STOP)
				stop_ff <= t_bit_ff;
		end
	end

	// =======
	// Assertions.
	a_ack_follows: assert property (req && !ack |=> ack)
		else $error("link answer missing");
	a_ack_single: assert property (ack |=> !ack)
		else $error("link answer longer than one cycle");
	a_ack_cause: assert property (ack |-> $past(req))
		else $error("link answer without order");
	a_req_held: assert property (req && !ack |=> req && $stable(addr)
		&& $stable(we) && $stable(wdata))
		else $error("link order changed before answer");
	a_req_released: assert property (ack |=> !req)
		else $error("link order not released");
	a_stopped_zero: assert property (ack && !t_we_ff && t_addr_ff != IDX_STOP
		&& (stop_ff || t_addr_ff == 2'h3) |-> rdata == 16'h0000)
		else $error("blocked read returned data");
	a_stop_readback: assert property (ack && !t_we_ff && t_addr_ff == IDX_STOP
		|-> rdata[STOP_BIT] == stop_ff)
		else $error("stop bit readback wrong");
	a_resv_one: assert property (ack && !t_we_ff && t_addr_ff == IDX_CH1
		&& !stop_ff |-> rdata[CONVERSION_TRIGGER_ENABLE_BIT] && rdata[15:8] == 8'h00)
		else $error("channel 1 reserved bit wrong");
	a_ch0_upper: assert property (ack && !t_we_ff && t_addr_ff == IDX_CH0
		|-> rdata[15:8] == 8'h00)
		else $error("channel 0 upper byte not zero");

	c_stop_write: cover property (ack && t_we_ff && t_addr_ff == IDX_STOP);
	c_blocked: cover property (ack && !t_we_ff && stop_ff && t_addr_ff == IDX_CH0);
	c_unmapped: cover property (ack && t_addr_ff == 2'h3);
endmodule : tsoc_asserts

// file: timer8_status_output_ctrl_tb.sv
`timescale 1ns/1ps
// =======
// Bench: Wishbone orders into the controller, device events by hand.
module timer8_status_output_ctrl_tb
	import tsoc_pkg::*;
;
	logic                sys_clk, arst_n, cyc, stb, wwe, wack, conv, run;
	logic                stby;
	logic [3:0]          adr;
	logic [31:0]         wdat, wrd;
	logic [NCH-1:0][7:0] cv, ca, cb;
	logic [NCH-1:0]      upd, iea, ieb, iew, xa, xb, dsel;
	logic [NCH-1:0]      irqa, irqb, irqw, tmo, oe;
	int                  n_fail, checks_done, cyc_cnt;

	tsoc_if tsoc_if_inst ();
	tsoc_host tsoc_host_inst (.sys_clk(sys_clk), .arst_n(arst_n),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wwe), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wrd), .wb_ack_o(wack),
		.link(tsoc_if_inst.host));
	tsoc_dev tsoc_dev_inst (.sys_clk(sys_clk), .arst_n(arst_n),
		.bus(tsoc_if_inst.dev), .hw_standby(stby), .cnt_val(cv),
		.constant_a(ca), .constant_b(cb), .cnt_upd(upd), .ie_match_a(iea),
		.ie_match_b(ieb), .ie_wrap(iew), .xfer_done_a(xa), .xfer_done_b(xb),
		.disable_after_transfer_select(dsel), .match_a_irq(irqa),
		.match_b_irq(irqb), .wrap_irq(irqw), .conv_start(conv), .tmo(tmo),
		.tmo_oe(oe), .timer_run(run));
	tsoc_asserts tsoc_asserts_inst (.sys_clk(sys_clk), .arst_n(arst_n),
		.hw_standby(stby),
		.req(tsoc_if_inst.req), .we(tsoc_if_inst.we),
		.addr(tsoc_if_inst.addr), .wdata(tsoc_if_inst.wdata),
		.rdata(tsoc_if_inst.rdata), .ack(tsoc_if_inst.ack));

	// =======
	// Helpers.
	task automatic stop_test;
		$display("checks %0d errors %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : chk

	// One classic cycle; ack and data are taken at the same edge.
	task automatic wb(input logic w, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge sys_clk);
		{cyc, stb, wwe, adr, wdat} <= {2'b11, w, a, d};
		@(posedge sys_clk);
		while (wack !== 1'b1)
			@(posedge sys_clk);
		q = wrd;
		{cyc, stb} <= 2'b00;
	endtask : wb

	// Link access: order, then poll until the controller is idle.
	task automatic lk(input logic w, input logic [1:0] a,
		input logic [15:0] d, output logic [15:0] q);
		logic [31:0] r;
		wb(1'b1, WB_CMD, {1'b1, 12'h000, w, a, d}, r);
		r = 32'h0001_0000;
		while (r[STAT_BUSY] !== 1'b0)
			wb(1'b0, WB_STAT, 32'h0000_0000, r);
		q = r[15:0];
	endtask : lk

	task automatic rdc(input logic [1:0] a, input logic [15:0] e);
		logic [15:0] q;
		lk(1'b0, a, 16'h0000, q);
		chk(32'(e), 32'(q));
	endtask : rdc

	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		logic [15:0] q;
		lk(1'b1, a, d, q);
	endtask : wr

	// Counter event: value and update strobe for one cycle. It returns
	// one edge later, while the outputs launched by the event stand.
	task automatic ev(input int ch, input logic [7:0] v);
		@(posedge sys_clk);
		cv[ch] <= v;
		upd[ch] <= 1'b1;
		@(posedge sys_clk);
		upd[ch] <= 1'b0;
		@(posedge sys_clk);
	endtask : ev

	// =======
	// Scenarios.
	task automatic t_reset;
		logic [31:0] r;
		rdc(IDX_STOP, RST_STOP);
		chk(32'h0, 32'({run, tmo, oe}));
		wr(IDX_CH0, 16'h000F);
		rdc(IDX_CH0, 16'h0000);
		rdc(2'h3, 16'h0000);
		wb(1'b0, 4'h8, 32'h0000_0000, r);
		chk(32'h0, r);
		wr(IDX_STOP, 16'h2FFF);
		chk(32'h1, 32'(run));
		rdc(IDX_CH0, RST_CH0);
		wr(IDX_CH1, 16'h0000);
		rdc(IDX_CH1, RST_CH1);
	endtask : t_reset

	task automatic t_flags;
		ca[0] <= 8'hFF;
		cb[0] <= 8'hFF;
		ev(0, 8'hFF);
		chk(32'h0, 32'({irqa[0], irqb[0], irqw[0]}));
		{iea, ieb, iew} <= 6'h3F;
		@(posedge sys_clk);
		chk(32'h7, 32'({irqa[0], irqb[0], irqw[0]}));
		rdc(IDX_CH0, 16'h00E0);
		wr(IDX_CH0, 16'h00E0);
		wr(IDX_CH0, 16'h0000);
		rdc(IDX_CH0, 16'h00E0);
		wr(IDX_CH0, 16'h0000);
		rdc(IDX_CH0, 16'h0000);
		chk(32'h0, 32'({irqa[0], irqb[0], irqw[0]}));
	endtask : t_flags

	task automatic t_adc;
		wr(IDX_CH0, 16'h0010);
		ca[0] <= 8'h20;
		ev(0, 8'h20);
		chk(32'h1, 32'(conv));
		@(posedge sys_clk);
		chk(32'h0, 32'(conv));
		wr(IDX_CH0, 16'h0000);
		ev(0, 8'h20);
		chk(32'h0, 32'(conv));
		rdc(IDX_CH0, 16'h0040);
		wr(IDX_CH0, 16'h0000);
		wr(IDX_STOP, 16'h3FFF);
		chk(32'h0, 32'(run));
		ev(0, 8'hFF);
		wr(IDX_STOP, 16'h2FFF);
		rdc(IDX_CH0, 16'h0000);
	endtask : t_adc

	task automatic t_xfer;
		ca[1] <= 8'h33;
		cb[1] <= 8'h33;
		ev(1, 8'h33);
		chk(32'h6, 32'({irqa[1], irqb[1], irqw[1]}));
		dsel <= 2'b10;
		{xa, xb} <= 4'hA;
		@(posedge sys_clk);
		{xa, xb, dsel} <= 6'h00;
		rdc(IDX_CH1, 16'h00D0);
		xb <= 2'b10;
		@(posedge sys_clk);
		xb <= 2'b00;
		rdc(IDX_CH1, 16'h0050);
	endtask : t_xfer

	// Orders chosen so that every action changes or visibly keeps tmo.
	task automatic t_out;
		logic        e;
		logic [1:0]  k;
		logic [15:0] ord;
		logic [11:0] pri;
		e = 1'b0;
		ord = 16'b11_00_10_01_00_11_01_10;
		pri = 12'b0110_1011_1001;
		ca[1] <= 8'h11;
		cb[1] <= 8'h22;
		for (int i = 0; i < 8; i++) begin
			k = ord[2*i +: 2];
			wr(IDX_CH1, (i < 4) ? 16'(k) : 16'(k) << 2);
			chk(32'(k != ACT_NONE), 32'(oe[1]));
			ev(1, (i < 4) ? 8'h11 : 8'h22);
			e = (k == ACT_TGL) ? ~e : (k == ACT_ONE) ? 1'b1 :
				(k == ACT_ZERO) ? 1'b0 : e;
			chk(32'(e), 32'(tmo[1]));
		end
		ca[1] <= 8'h44;
		cb[1] <= 8'h44;
		for (int i = 0; i < 3; i++) begin
			wr(IDX_CH1, 16'(pri[4*i +: 4]));
			ev(1, 8'h44);
			chk(32'(i % 2 == 0), 32'(tmo[1]));
		end
	endtask : t_out

	// Hardware standby: every register and output back to reset.
	// The link stays idle until the synchroniser has let go.
	task automatic t_stby;
		wr(IDX_CH0, 16'h001F);
		ev(0, 8'hFF);
		chk(32'h3, 32'({tmo[0], oe[0]}));
		stby <= 1'b1;
		repeat (4) @(posedge sys_clk);
		stby <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk(32'h0, 32'({run, tmo, oe, irqa, irqb, irqw}));
		rdc(IDX_STOP, RST_STOP);
		wr(IDX_STOP, 16'h2FFF);
		rdc(IDX_CH0, RST_CH0);
		rdc(IDX_CH1, RST_CH1);
	endtask : t_stby

	// =======
	// Clock, watchdog and main sequence.
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// A hang ends the run as a failure.
	always @(posedge sys_clk) begin
		cyc_cnt++;
		if (cyc_cnt > 20000) begin
			n_fail++;
			stop_test();
		end
	end

	initial begin
		{arst_n, stby, cyc, stb, wwe, adr, wdat} = '0;
		{cv, ca, cb, upd, iea, ieb, iew, xa, xb, dsel} = '0;
		{n_fail, checks_done, cyc_cnt} = '0;
		repeat (2) @(posedge sys_clk);
		arst_n <= 1'b1;
		t_reset();
		t_flags();
		t_adc();
		t_xfer();
		t_out();
		t_stby();
		stop_test();
	end
endmodule : timer8_status_output_ctrl_tb
